// ---- core/uri_irq_ctrl.sv ----
// uri_irq_ctrl: interrupt generation, priority and clearing of one uart
// channel, its register file and the reset states of its outputs.
// assumes a receive/transmit datapath beside it that reports fifo levels,
// character events and errors, and an avalon-mm master on sys_clk.
//
// Operation
// [R1] pin reset, power-on reset and software reset load identical register states.
// [R2] divisor bytes, prescale and four flow characters survive every reset.
// [R3] reset outputs: tx high, rts/dtr high, infrared low, dma ready rx high, tx low.
// [R4] after reset interrupt pins float unless select is high, then int drives low.
// [R5] seven enable-gated interrupt types, pending and type shown in six-bit source.
// [R6] codes: line status 06 first, receive data 04 second, timeout 0c third.
// [R7] codes: tx ready 02, modem 00, xoff/special 10, flow pins 20.
// [R8] line status bit 7 set while any erroneous character stays in receive fifo.
// [R9] line status bits 4:2 show head character errors, zero when fifo is empty.
// [R10] xoff interrupt clears on xon; special character interrupt clears on source read.
// [R11] line status interrupt raised by line status bits 1, 2, 3, 4 or 7.
// [R12] timeout raised after four character times without data, below trigger.
// [R13] tx ready raised at trigger or empty fifo, or shifter empty in rs485 mode.
// [R14] modem interrupt raised by any modem status change bit 0 to 3.
// [R15] under auto flow control a rising cts input or rts output raises flow interrupt.
// [R16] error interrupt clears when error characters leave; overrun clears on status read.
// [R17] receive data interrupt clears once fifo level drops below trigger.
// [R18] timeout interrupt clears when the receive holding register is read.
// [R19] tx ready interrupt clears on source read or transmit holding write.
// [R20] modem and flow pin interrupts clear on modem status read.
// [R21] enable bits 3:0 let receiver and transmitter conditions drive the request pin.
// [R22] with enable bits 3:0 clear the host polls line status instead.
// [R23] timeout count restarts at each received stop bit and each fifo read.
// [R24] highest priority enabled source is shown; 01 when nothing pending.
// [R25] disabled sources never reach the request output or the source field.
//
// The implementer's own choices: the Avalon-MM interface to the registers and the address map.
`include "uri_params.svh"
`timescale 1ns/1ps
`default_nettype none

module uri_irq_ctrl
  import uri_pkg::*;
#(
  parameter int FIFO_DEPTH = `URI_FIFO_DEPTH,
  parameter int TIMEOUT_CHARS = `URI_TIMEOUT_CHARS
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output var logic [31:0] avs_readdata,
  output var logic avs_waitrequest,
  input wire logic irqOutputSelect,
  input wire logic [7:0] rxHeadData,
  input wire logic [2:0] rxHeadErr,
  input wire logic [6:0] rxLevel,
  input wire logic rxAtTrigger,
  input wire logic rxCharValid,
  input wire logic [2:0] rxCharErr,
  input wire logic rxOverrun,
  input wire logic charTick,
  input wire logic txFifoEmpty,
  input wire logic txAtTrigger,
  input wire logic txHasSpace,
  input wire logic txAllEmpty,
  input wire logic txSerial,
  input wire logic [3:0] modemInN,
  input wire logic rtsHalt,
  input wire logic xoffSeen,
  input wire logic xonSeen,
  input wire logic specialSeen,
  output var logic rxPop,
  output var logic txPush,
  output var logic [7:0] txData,
  output var logic txPin,
  output var logic rtsPinN,
  output var logic dtrPinN,
  output var logic infraredTxOut,
  output var logic rxDmaReadyN,
  output var logic txDmaReadyN,
  output var logic auxOutputTwoN,
  output var logic intOut,
  output var logic intOeN,
  output var logic irqReqN,
  output var logic irqOeN,
  output var logic [15:0] divisor,
  output var logic [7:0] prescale,
  output var logic [31:0] flowChars,
  output var logic [7:0] lineCtlOut,
  output var logic [7:0] enhFeatOut,
  output var logic [7:0] fifoCtlOut
);

  generate
    if (FIFO_DEPTH < 1 || FIFO_DEPTH > 64) begin : gBadDepth
      $error("FIFO_DEPTH must lie in 1..64");
    end
    if (TIMEOUT_CHARS < 1 || TIMEOUT_CHARS > 7) begin : gBadTimeout
      $error("TIMEOUT_CHARS must lie in 1..7");
    end
  endgenerate

  uri_state_t s;
  uri_state_t next_s;
  uri_keep_t k;
  uri_keep_t next_k;

  logic [3:0] modemChange;
  logic [7:0] wd;
  logic req;
  logic rdAcc;
  logic wrAcc;
  logic rxEmpty;
  logic [2:0] headShown;
  logic fifoErr;
  logic [7:0] lineStatus;
  logic [7:0] modemStatus;
  logic [7:0] intSource;
  logic [5:0] srcCode;
  logic pendLine;
  logic pendRx;
  logic pendTimeout;
  logic pendTx;
  logic pendModem;
  logic pendXoff;
  logic pendFlow;
  logic pending;
  logic outEnable;
  logic txCond;
  logic ctsNow;
  logic [31:0] readMux;

  // true when the bus address selects the word at byte offset off
  function automatic logic isReg(input logic [7:0] addr, input logic [7:0] off);
    isReg = ({addr[7:2], 2'b00} == off);
  endfunction

  // common register state of all three resets
  function automatic uri_state_t resetState();
    uri_state_t r;
    r = '0;
    r.intEnable = `URI_RST_ZERO;
    r.lineCtl = `URI_RST_LINE_CTL;
    r.scratch = `URI_RST_SCRATCH;
    r.featureCtl = `URI_RST_FEATURE_CTL;
    r.txPin = 1'b1;
    r.rtsPinN = 1'b1;
    r.dtrPinN = 1'b1;
    r.infraredTxOut = 1'b0;
    r.rxDmaReadyN = 1'b1;
    r.txDmaReadyN = 1'b0;
    r.auxOutputTwoN = 1'b1;
    r.intOut = 1'b0;
    r.intOeN = 1'b1;
    r.irqReqN = 1'b1;
    r.irqOeN = 1'b1;
    r.ctsPrev = 1'b1;
    r.waitReq = 1'b1;
    resetState = r; // see [R3] see [R4]
  endfunction

  // modem input change detection, one bit per input
  generate
    for (genvar i = 0; i < 4; i++) begin : gModem
      assign modemChange[i] = s.primed & (s.modemPrev[i] ^ modemInN[i]);
    end
  endgenerate

  always_comb begin
    wd = avs_writedata[7:0];
    req = avs_read | avs_write;
    rdAcc = avs_read & ~s.waitReq;
    wrAcc = avs_write & ~s.waitReq;
    rxEmpty = (rxLevel == 7'h00);
    headShown = rxEmpty ? 3'h0 : rxHeadErr; // see [R9]
    fifoErr = (s.errCount != 7'h00); // see [R8]
    lineStatus = {fifoErr, txAllEmpty, txFifoEmpty, headShown, s.overrunFlag, ~rxEmpty};
    modemStatus = {~modemInN, s.modemDelta};
    ctsNow = modemInN[0];
    // enable-gated pending sources
    pendLine = s.intEnable[`URI_IEN_LINE] & (|lineStatus[4:1] | lineStatus[7]); // see [R11]
    pendRx = s.intEnable[`URI_IEN_RXDATA] & rxAtTrigger; // see [R17]
    pendTimeout = s.intEnable[`URI_IEN_RXDATA] & s.timeoutFlag;
    pendTx = s.intEnable[`URI_IEN_TXREADY] & s.txReadyFlag;
    pendModem = s.intEnable[`URI_IEN_MODEM] & (|s.modemDelta); // see [R14]
    pendXoff = s.intEnable[`URI_IEN_XOFF] & s.enhFeat[`URI_ENH_ENABLE]
      & (s.xoffFlag | s.specialFlag);
    pendFlow = s.enhFeat[`URI_ENH_ENABLE]
      & ((s.intEnable[`URI_IEN_RTS] & s.rtsFlowFlag)
      | (s.intEnable[`URI_IEN_CTS] & s.ctsFlowFlag)); // see [R25]
    // priority encoder, level 1 first
    if (pendLine) begin
      srcCode = `URI_SRC_LINE; // see [R6]
    end else if (pendRx) begin
      srcCode = `URI_SRC_RXDATA;
    end else if (pendTimeout) begin
      srcCode = `URI_SRC_TIMEOUT;
    end else if (pendTx) begin
      srcCode = `URI_SRC_TXREADY; // see [R7]
    end else if (pendModem) begin
      srcCode = `URI_SRC_MODEM;
    end else if (pendXoff) begin
      srcCode = `URI_SRC_XOFF;
    end else if (pendFlow) begin
      srcCode = `URI_SRC_FLOW;
    end else begin
      srcCode = `URI_SRC_NONE; // see [R24]
    end
    pending = (srcCode != `URI_SRC_NONE); // see [R5] see [R21]
    intSource = {s.fifoCtl[`URI_FCTL_FIFO_EN], s.fifoCtl[`URI_FCTL_FIFO_EN], srcCode};
    outEnable = irqOutputSelect | s.modemCtl[`URI_MCTL_IRQ_EN];
    txCond = s.featureCtl[`URI_FEAT_AUTO485] ? txAllEmpty
      : (txFifoEmpty | txAtTrigger); // see [R13]
    // read data mux
    readMux = 32'h0000_0000;
    if (isReg(avs_address, `URI_OFF_HOLDING)) readMux[7:0] = rxHeadData;
    if (isReg(avs_address, `URI_OFF_INT_ENABLE)) readMux[7:0] = s.intEnable;
    if (isReg(avs_address, `URI_OFF_INT_SOURCE)) readMux[7:0] = intSource;
    if (isReg(avs_address, `URI_OFF_LINE_CTL)) readMux[7:0] = s.lineCtl;
    if (isReg(avs_address, `URI_OFF_MODEM_CTL)) readMux[7:0] = s.modemCtl;
    if (isReg(avs_address, `URI_OFF_LINE_STATUS)) readMux[7:0] = lineStatus; // see [R22]
    if (isReg(avs_address, `URI_OFF_MODEM_STATUS)) readMux[7:0] = modemStatus;
    if (isReg(avs_address, `URI_OFF_SCRATCH)) readMux[7:0] = s.scratch;
    if (isReg(avs_address, `URI_OFF_DIV_LOW)) readMux[7:0] = k.divLow;
    if (isReg(avs_address, `URI_OFF_DIV_HIGH)) readMux[7:0] = k.divHigh;
    if (isReg(avs_address, `URI_OFF_DIV_FRAC)) readMux[7:0] = s.divFrac;
    if (isReg(avs_address, `URI_OFF_FEATURE_CTL)) readMux[7:0] = s.featureCtl;
    if (isReg(avs_address, `URI_OFF_ENH_FEAT)) readMux[7:0] = s.enhFeat;
    if (isReg(avs_address, `URI_OFF_TRIG_LEVEL)) readMux[7:0] = s.trigLevel;
    if (isReg(avs_address, `URI_OFF_LEVEL_COUNT)) readMux[7:0] = {1'b0, rxLevel};
    if (isReg(avs_address, `URI_OFF_HALT_RESUME)) readMux[7:0] = s.haltResume;
    if (isReg(avs_address, `URI_OFF_FIFO_TRIG)) readMux[7:0] = s.fifoTrig;
    if (isReg(avs_address, `URI_OFF_READY_FLAGS)) begin
      readMux[7:0] = {4'h0, 2'b11, s.rxDmaReadyN, ~s.txDmaReadyN};
    end
    if (isReg(avs_address, `URI_OFF_RESUME_ONE)) readMux[7:0] = k.resumeOne;
    if (isReg(avs_address, `URI_OFF_RESUME_TWO)) readMux[7:0] = k.resumeTwo;
    if (isReg(avs_address, `URI_OFF_PAUSE_ONE)) readMux[7:0] = k.pauseOne;
    if (isReg(avs_address, `URI_OFF_PAUSE_TWO)) readMux[7:0] = k.pauseTwo;
    if (isReg(avs_address, `URI_OFF_PRESCALE)) readMux[7:0] = k.prescale;
  end

  always_comb begin
    next_s = s;
    next_k = k;
    next_s.rxPop = 1'b0;
    next_s.txPush = 1'b0;
    // one wait cycle per access, then accept
    next_s.waitReq = ~(req & s.waitReq);
    if (avs_read & s.waitReq) begin
      next_s.readData = readMux;
    end
    // register writes
    if (wrAcc) begin
      if (isReg(avs_address, `URI_OFF_HOLDING)) begin
        next_s.txPush = 1'b1;
        next_s.txData = wd;
        next_s.txReadyFlag = 1'b0; // see [R19]
      end
      if (isReg(avs_address, `URI_OFF_INT_ENABLE)) next_s.intEnable = wd;
      if (isReg(avs_address, `URI_OFF_INT_SOURCE)) next_s.fifoCtl = wd;
      if (isReg(avs_address, `URI_OFF_LINE_CTL)) next_s.lineCtl = wd;
      if (isReg(avs_address, `URI_OFF_MODEM_CTL)) next_s.modemCtl = wd;
      if (isReg(avs_address, `URI_OFF_SCRATCH)) next_s.scratch = wd;
      if (isReg(avs_address, `URI_OFF_DIV_LOW)) next_k.divLow = wd;
      if (isReg(avs_address, `URI_OFF_DIV_HIGH)) next_k.divHigh = wd;
      if (isReg(avs_address, `URI_OFF_DIV_FRAC)) next_s.divFrac = wd;
      if (isReg(avs_address, `URI_OFF_FEATURE_CTL)) next_s.featureCtl = wd;
      if (isReg(avs_address, `URI_OFF_ENH_FEAT)) next_s.enhFeat = wd;
      if (isReg(avs_address, `URI_OFF_TRIG_LEVEL)) next_s.trigLevel = wd;
      if (isReg(avs_address, `URI_OFF_HALT_RESUME)) next_s.haltResume = wd;
      if (isReg(avs_address, `URI_OFF_FIFO_TRIG)) next_s.fifoTrig = wd;
      if (isReg(avs_address, `URI_OFF_RESUME_ONE)) next_k.resumeOne = wd;
      if (isReg(avs_address, `URI_OFF_RESUME_TWO)) next_k.resumeTwo = wd;
      if (isReg(avs_address, `URI_OFF_PAUSE_ONE)) next_k.pauseOne = wd;
      if (isReg(avs_address, `URI_OFF_PAUSE_TWO)) next_k.pauseTwo = wd;
      if (isReg(avs_address, `URI_OFF_PRESCALE)) next_k.prescale = wd;
    end
    // clearing side effects of reads
    if (rdAcc && isReg(avs_address, `URI_OFF_HOLDING)) begin
      next_s.rxPop = ~rxEmpty;
      next_s.timeoutFlag = 1'b0; // see [R18]
      if (!rxEmpty && rxHeadErr != 3'h0 && fifoErr) begin
        next_s.errCount = 7'(s.errCount - 7'h01); // see [R16]
      end
    end
    if (rdAcc && isReg(avs_address, `URI_OFF_LINE_STATUS)) begin
      next_s.overrunFlag = 1'b0; // see [R16]
    end
    if (rdAcc && isReg(avs_address, `URI_OFF_MODEM_STATUS)) begin
      next_s.modemDelta = 4'h0; // see [R20]
      next_s.rtsFlowFlag = 1'b0;
      next_s.ctsFlowFlag = 1'b0;
    end
    if (rdAcc && isReg(avs_address, `URI_OFF_INT_SOURCE)) begin
      next_s.txReadyFlag = 1'b0; // see [R19]
      next_s.specialFlag = 1'b0; // see [R10]
    end
    if (xonSeen) next_s.xoffFlag = 1'b0; // see [R10]
    // receive error bookkeeping, set after clear so events win
    if (rxCharValid && rxCharErr != 3'h0) begin
      next_s.errCount = 7'(next_s.errCount + 7'h01); // see [R8]
    end
    if (rxOverrun) next_s.overrunFlag = 1'b1;
    // character timeout
    if (rxCharValid || (rdAcc && isReg(avs_address, `URI_OFF_HOLDING))) begin
      next_s.toCount = 3'h0; // see [R23]
    end else if (rxEmpty || rxAtTrigger) begin
      next_s.toCount = 3'h0;
    end else if (charTick && !s.timeoutFlag) begin
      next_s.toCount = 3'(s.toCount + 3'h1);
      if (3'(s.toCount + 3'h1) == 3'(TIMEOUT_CHARS)) begin
        next_s.timeoutFlag = 1'b1; // see [R12]
        next_s.toCount = 3'h0;
      end
    end
    // transmit ready on a rising condition
    next_s.txCondPrev = txCond;
    if (txCond && !s.txCondPrev) next_s.txReadyFlag = 1'b1; // see [R13]
    // modem input changes
    next_s.primed = 1'b1;
    next_s.modemPrev = modemInN;
    next_s.modemDelta = next_s.modemDelta | modemChange; // see [R14]
    // software flow control events
    if (xoffSeen && s.enhFeat[`URI_ENH_ENABLE]) next_s.xoffFlag = 1'b1;
    if (specialSeen && s.enhFeat[`URI_ENH_ENABLE]) next_s.specialFlag = 1'b1;
    // hardware flow pins, low to high
    next_s.ctsPrev = ctsNow;
    if (s.enhFeat[`URI_ENH_AUTO_CTS] && ctsNow && !s.ctsPrev) begin
      next_s.ctsFlowFlag = 1'b1; // see [R15]
    end
    next_s.rtsPinN = ~s.modemCtl[`URI_MCTL_RTS] | (s.enhFeat[`URI_ENH_AUTO_RTS] & rtsHalt);
    if (s.enhFeat[`URI_ENH_AUTO_RTS] && next_s.rtsPinN && !s.rtsPinN) begin
      next_s.rtsFlowFlag = 1'b1; // see [R15]
    end
    // pins
    next_s.txPin = s.lineCtl[`URI_LCTL_BREAK] ? 1'b0 : txSerial;
    next_s.dtrPinN = ~s.modemCtl[`URI_MCTL_DTR];
    next_s.infraredTxOut = s.modemCtl[`URI_MCTL_INFRARED] & ~next_s.txPin;
    next_s.auxOutputTwoN = ~s.modemCtl[`URI_MCTL_IRQ_EN];
    if (s.fifoCtl[`URI_FCTL_DMA_MODE] && s.fifoCtl[`URI_FCTL_FIFO_EN]) begin
      next_s.rxDmaReadyN = ~((rxAtTrigger | s.timeoutFlag) & ~rxEmpty & ~fifoErr);
      next_s.txDmaReadyN = ~txHasSpace;
    end else begin
      next_s.rxDmaReadyN = rxEmpty;
      next_s.txDmaReadyN = ~txFifoEmpty;
    end
    // interrupt pins
    next_s.intOut = pending;
    next_s.intOeN = ~outEnable; // see [R4]
    next_s.irqReqN = ~pending;
    next_s.irqOeN = ~outEnable; // see [R21]
    // software reset: same state as the reset pin, kept contents untouched
    if (wrAcc && isReg(avs_address, `URI_OFF_SOFT_RESET) && wd[0]) begin
      next_s = resetState(); // see [R1]
      next_k = k; // see [R2]
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= resetState(); // see [R1]
    end else begin
      s <= next_s;
    end
  end

  // contents that no reset touches
  always_ff @(posedge sys_clk) begin
    k <= next_k; // see [R2]
  end

  assign avs_readdata = s.readData;
  assign avs_waitrequest = s.waitReq;
  assign rxPop = s.rxPop;
  assign txPush = s.txPush;
  assign txData = s.txData;
  assign txPin = s.txPin;
  assign rtsPinN = s.rtsPinN;
  assign dtrPinN = s.dtrPinN;
  assign infraredTxOut = s.infraredTxOut;
  assign rxDmaReadyN = s.rxDmaReadyN;
  assign txDmaReadyN = s.txDmaReadyN;
  assign auxOutputTwoN = s.auxOutputTwoN;
  assign intOut = s.intOut;
  assign intOeN = s.intOeN;
  assign irqReqN = s.irqReqN;
  assign irqOeN = s.irqOeN;
  assign divisor = {k.divHigh, k.divLow};
  assign prescale = k.prescale;
  assign flowChars = {k.pauseTwo, k.pauseOne, k.resumeTwo, k.resumeOne};
  assign lineCtlOut = s.lineCtl;
  assign enhFeatOut = s.enhFeat;
  assign fifoCtlOut = s.fifoCtl;

endmodule

`default_nettype wire

// ---- core/uri_params.svh ----
// uri_params.svh: offsets, field positions, reset values and counts for the
// uart reset and interrupt block; assumes inclusion by bare name from core/.
`ifndef URI_PARAMS_SVH
`define URI_PARAMS_SVH

// byte offsets on the register bus, one 32-bit word each
`define URI_OFF_HOLDING 8'h00
`define URI_OFF_INT_ENABLE 8'h04
`define URI_OFF_INT_SOURCE 8'h08
`define URI_OFF_LINE_CTL 8'h0c
`define URI_OFF_MODEM_CTL 8'h10
`define URI_OFF_LINE_STATUS 8'h14
`define URI_OFF_MODEM_STATUS 8'h18
`define URI_OFF_SCRATCH 8'h1c
`define URI_OFF_DIV_LOW 8'h20
`define URI_OFF_DIV_HIGH 8'h24
`define URI_OFF_DIV_FRAC 8'h28
`define URI_OFF_FEATURE_CTL 8'h2c
`define URI_OFF_ENH_FEAT 8'h30
`define URI_OFF_TRIG_LEVEL 8'h34
`define URI_OFF_LEVEL_COUNT 8'h38
`define URI_OFF_HALT_RESUME 8'h3c
`define URI_OFF_FIFO_TRIG 8'h40
`define URI_OFF_READY_FLAGS 8'h44
`define URI_OFF_RESUME_ONE 8'h48
`define URI_OFF_RESUME_TWO 8'h4c
`define URI_OFF_PAUSE_ONE 8'h50
`define URI_OFF_PAUSE_TWO 8'h54
`define URI_OFF_PRESCALE 8'h58
`define URI_OFF_SOFT_RESET 8'h5c

// reset values
`define URI_RST_LINE_CTL 8'h1d
`define URI_RST_SCRATCH 8'hff
`define URI_RST_FEATURE_CTL 8'h20
`define URI_RST_ZERO 8'h00

// interrupt source codes
`define URI_SRC_NONE 6'h01
`define URI_SRC_LINE 6'h06
`define URI_SRC_RXDATA 6'h04
`define URI_SRC_TIMEOUT 6'h0c
`define URI_SRC_TXREADY 6'h02
`define URI_SRC_MODEM 6'h00
`define URI_SRC_XOFF 6'h10
`define URI_SRC_FLOW 6'h20

// interrupt enable bit positions
`define URI_IEN_RXDATA 0
`define URI_IEN_TXREADY 1
`define URI_IEN_LINE 2
`define URI_IEN_MODEM 3
`define URI_IEN_XOFF 5
`define URI_IEN_RTS 6
`define URI_IEN_CTS 7

// other control bit positions
`define URI_ENH_ENABLE 4
`define URI_ENH_AUTO_RTS 6
`define URI_ENH_AUTO_CTS 7
`define URI_MCTL_DTR 0
`define URI_MCTL_RTS 1
`define URI_MCTL_IRQ_EN 3
`define URI_MCTL_INFRARED 6
`define URI_LCTL_BREAK 6
`define URI_FCTL_FIFO_EN 0
`define URI_FCTL_DMA_MODE 3
`define URI_FEAT_AUTO485 4

// counts
`define URI_TIMEOUT_CHARS 4
`define URI_FIFO_DEPTH 64

`endif

// ---- core/uri_pkg.sv ----
// uri_pkg: state types of the uart reset and interrupt block.
// assumes the params header sits beside it.
package uri_pkg;

  typedef struct packed {
    logic [7:0] intEnable;
    logic [7:0] fifoCtl;
    logic [7:0] lineCtl;
    logic [7:0] modemCtl;
    logic [7:0] scratch;
    logic [7:0] divFrac;
    logic [7:0] featureCtl;
    logic [7:0] enhFeat;
    logic [7:0] trigLevel;
    logic [7:0] haltResume;
    logic [7:0] fifoTrig;
    logic overrunFlag;
    logic [6:0] errCount;
    logic [2:0] toCount;
    logic timeoutFlag;
    logic txReadyFlag;
    logic txCondPrev;
    logic [3:0] modemDelta;
    logic [3:0] modemPrev;
    logic primed;
    logic xoffFlag;
    logic specialFlag;
    logic rtsFlowFlag;
    logic ctsFlowFlag;
    logic ctsPrev;
    logic txPin;
    logic rtsPinN;
    logic dtrPinN;
    logic infraredTxOut;
    logic rxDmaReadyN;
    logic txDmaReadyN;
    logic auxOutputTwoN;
    logic intOut;
    logic intOeN;
    logic irqReqN;
    logic irqOeN;
    logic [31:0] readData;
    logic waitReq;
    logic rxPop;
    logic txPush;
    logic [7:0] txData;
  } uri_state_t;

  // contents that survive every reset
  typedef struct packed {
    logic [7:0] divLow;
    logic [7:0] divHigh;
    logic [7:0] prescale;
    logic [7:0] resumeOne;
    logic [7:0] resumeTwo;
    logic [7:0] pauseOne;
    logic [7:0] pauseTwo;
  } uri_keep_t;

endpackage

// ---- tb/uri_irq_chk.sv ----
// checker for uri_irq_ctrl: port relations over time
// assumes binding to the design top
`timescale 1ns/1ps
`default_nettype none
module uri_irq_chk (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic irqOutputSelect,
  input wire logic [2:0] rxHeadErr,
  input wire logic [6:0] rxLevel,
  input wire logic rxPop,
  input wire logic txPush,
  input wire logic [7:0] txData,
  input wire logic rtsPinN,
  input wire logic dtrPinN,
  input wire logic auxOutputTwoN,
  input wire logic intOut,
  input wire logic intOeN,
  input wire logic irqOeN,
  input wire logic [15:0] divisor,
  input wire logic [31:0] flowChars
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic acc;
  assign acc = (avs_read || avs_write) && !avs_waitrequest;
  AST_RST_PINS: assert property ($rose(rst_n) |->
    rtsPinN && dtrPinN && auxOutputTwoN && !intOut) else $error("reset pins");
  AST_INT_DRIVEN: assert property ($rose(rst_n) && irqOutputSelect |=>
    !intOeN && !intOut) else $error("int not driven");
  AST_INT_FLOAT: assert property ($rose(rst_n) && !irqOutputSelect |=>
    intOeN && irqOeN) else $error("pins not floating");
  AST_SOFT_RST: assert property (acc && avs_write && avs_address == 8'h5c
    && avs_writedata[0] |-> ##[1:3] rtsPinN && dtrPinN && auxOutputTwoN)
    else $error("soft reset pins");
  AST_KEEP: assert property (!$stable(divisor) || !$stable(flowChars) |->
    $past(acc && avs_write) || $past(acc && avs_write, 2))
    else $error("kept reg changed");
  AST_SRC_CODE: assert property (acc && avs_read && avs_address == 8'h08 |->
    avs_readdata[31:8] == 24'h00_0000 && avs_readdata[5:0] inside {6'h01, 6'h06,
    6'h04, 6'h0c, 6'h02, 6'h00, 6'h10, 6'h20}) else $error("bad source");
  AST_HEAD_ERR: assert property (acc && avs_read && avs_address == 8'h14 |->
    avs_readdata[4:2] == (rxLevel == 7'h00 ? 3'h0 : rxHeadErr))
    else $error("head errors");
  AST_TX_PUSH: assert property (acc && avs_write && avs_address == 8'h00 |=>
    txPush && txData == $past(avs_writedata[7:0])) else $error("no push");
  AST_RX_POP: assert property (acc && avs_read && avs_address == 8'h00
    && rxLevel != 7'h00 |=> rxPop) else $error("no pop");
endmodule
bind uri_irq_ctrl uri_irq_chk chk (.*);
`default_nettype wire

// ---- tb/uri_host.sv ----
// host model: avalon-mm master servicing the block's registers
// assumes tasks start just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module uri_host (
  input wire logic sys_clk,
  output logic [7:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  initial begin
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
  end
  // one access, held until waitrequest low
  task automatic access(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h00_0000, d};
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask
  // polled mode: read line status
  task automatic poll_status(output logic [7:0] q);
    access(1'b0, 8'h14, 8'h00, q);
  endtask
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// bench for uri_irq_ctrl: reset states, source priority and clearing
// assumes the host model drives the register bus
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic sys_clk = 1'b0, rst_n = 1'b0, irqOutputSelect = 1'b0, rxAtTrigger = 1'b0;
  logic txFifoEmpty = 1'b1, txAllEmpty = 1'b1, txAtTrigger = 1'b0, rtsHalt = 1'b0;
  logic [7:0] avs_address, q;
  logic [31:0] avs_writedata, avs_readdata;
  logic [2:0] rxHeadErr = 3'h0, rxCharErr = 3'h0;
  logic [6:0] rxLevel = 7'h00;
  logic [3:0] modemInN = 4'hf;
  logic [5:0] evt = 6'h00;
  logic [7:0] kept [6];
  wire logic rxCharValid, rxOverrun, charTick, xoffSeen, xonSeen, specialSeen;
  logic rxPop, txPush, intOut, irqReqN, avs_read, avs_write, avs_waitrequest;
  logic [7:0] txData;
  logic [15:0] divisor;
  logic [31:0] flowChars;
  int mismatches = 0, compares = 0;
  localparam logic [7:0] OFFS [15] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h1c, 8'h2c,
    8'h30, 8'h34, 8'h38, 8'h3c, 8'h40, 8'h44, 8'h28, 8'h60};
  localparam logic [7:0] RSTV [15] = '{8'h00, 8'h01, 8'h1d, 8'h00, 8'h60, 8'hff, 8'h20,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0f, 8'h00, 8'h00};
  localparam logic [7:0] KOFF [6] = '{8'h20, 8'h24, 8'h48, 8'h4c, 8'h50, 8'h54};
  assign {specialSeen, xonSeen, xoffSeen, charTick, rxOverrun, rxCharValid} = evt;
  always #10 sys_clk = ~sys_clk;
  uri_host host (.*);
  uri_irq_ctrl dut (.*, .rxHeadData(8'h00),
    .txHasSpace(1'b1), .txSerial(1'b1), .txPin(),
    .rtsPinN(), .dtrPinN(), .infraredTxOut(), .rxDmaReadyN(), .txDmaReadyN(),
    .auxOutputTwoN(), .intOeN(), .irqOeN(), .prescale(), .lineCtlOut(), .enhFeatOut(),
    .fifoCtlOut());
  task automatic check(input string what, input logic [31:0] exp, got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rd(input logic [7:0] a);
    host.access(1'b0, a, 8'h00, q);
  endtask
  task automatic wr(input logic [7:0] a, d);
    host.access(1'b1, a, d, q);
  endtask
  task automatic fire(input int b);
    evt[b] <= 1'b1;
    @(posedge sys_clk);
    evt[b] <= 1'b0;
    @(posedge sys_clk);
  endtask
  function automatic logic [2:0] head_err(input logic [6:0] lvl, input logic [2:0] e);
    return lvl == 7'h00 ? 3'h0 : e;
  endfunction
  task automatic src(input logic [5:0] exp);
    repeat (4) @(posedge sys_clk);
    check("int level", 32'(exp != 6'h01), 32'(intOut));
    rd(8'h08);
    check("source", 32'(exp), 32'(q[5:0]));
  endtask
  task automatic hw_reset(input logic sel);
    irqOutputSelect <= sel;
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    foreach (OFFS[i]) begin
      rd(OFFS[i]);
      check($sformatf("reg %h", OFFS[i]), 32'(RSTV[i]), 32'(q));
    end
  endtask
  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // hang limit: ten thousand cycles
  initial begin
    #200_000;
    mismatches++;
    test_done();
  end
  initial begin
    void'($urandom(60046));
    hw_reset(1'b0);
    foreach (OFFS[i]) wr(OFFS[i], 8'($urandom));
    foreach (KOFF[i]) begin
      kept[i] = 8'($urandom);
      wr(KOFF[i], kept[i]);
    end
    wr(8'h10, 8'h03);
    wr(8'h5c, 8'h01);
    foreach (OFFS[i]) begin
      rd(OFFS[i]);
      check($sformatf("soft %h", OFFS[i]), 32'(RSTV[i]), 32'(q));
    end
    hw_reset(1'b1);
    check("divisor", 32'({kept[1], kept[0]}), 32'(divisor));
    check("flow chars", {kept[5], kept[4], kept[3], kept[2]}, flowChars);
    $display("test resets done");
    txFifoEmpty <= 1'b0;
    wr(8'h30, 8'h10);
    txFifoEmpty <= 1'b1;
    wr(8'h04, 8'hef);
    src(6'h02);
    txFifoEmpty <= 1'b0;
    src(6'h01);
    txFifoEmpty <= 1'b1;
    wr(8'h00, 8'($urandom));
    src(6'h01);
    rxAtTrigger <= 1'b1;
    fire(1);
    src(6'h06);
    rd(8'h14);
    src(6'h04);
    rxAtTrigger <= 1'b0;
    src(6'h01);
    rxCharErr <= 3'h2;
    rxHeadErr <= 3'h2;
    rxLevel <= 7'h01;
    fire(0);
    rd(8'h14);
    check("lsr7", 32'h0000_0001, 32'(q[7]));
    src(6'h06);
    rd(8'h00);
    rxLevel <= 7'h00;
    rxHeadErr <= 3'h0;
    rd(8'h14);
    check("lsr7", 32'h0000_0000, 32'(q[7]));
    src(6'h01);
    $display("test line and data done");
    rxLevel <= 7'h02;
    repeat (3) fire(2);
    rd(8'h00);
    repeat (3) fire(2);
    src(6'h01);
    fire(2);
    src(6'h0c);
    rd(8'h00);
    src(6'h01);
    for (int i = 0; i < 4; i++) begin
      modemInN[i] <= ~modemInN[i];
      src(6'h00);
      rd(8'h18);
      src(6'h01);
    end
    fire(3);
    src(6'h10);
    src(6'h10);
    fire(4);
    src(6'h01);
    fire(5);
    src(6'h10);
    src(6'h01);
    wr(8'h30, 8'h90);
    wr(8'h04, 8'he7);
    modemInN[0] <= 1'b1;
    src(6'h20);
    rd(8'h18);
    src(6'h01);
    $display("test sources done");
    wr(8'h04, 8'h00);
    for (int i = 0; i < 8; i++) begin
      rxLevel <= 7'($urandom_range(2));
      rxHeadErr <= 3'($urandom);
      @(posedge sys_clk);
      host.poll_status(q);
      check("head errors", 32'(head_err(rxLevel, rxHeadErr)), 32'(q[4:2]));
    end
    $display("test head done");
    test_done();
  end
endmodule
`default_nettype wire
